// file: bench/otpl_ctrl_tb.sv
// Self-checking bench of the OTP program and lock controller
`timescale 1ns/1ps

module otpl_ctrl_tb;
  logic        mclk_i = 1'b0;    // 250 MHz clock
  logic        arst_n_i = 1'b0;  // Power-up reset
  logic        blank = 1'b0;     // Fresh part request
  logic        fba_we_i = 1'b0;  // Block address strobe
  logic [15:0] fba_i = 16'h0000; // Block address
  logic        prog_req_i = 1'b0; // Program pulse
  logic [5:0]  page_i = 6'h00;   // Program page
  logic        erase_req_i = 1'b0; // Erase pulse
  logic [3:0]  rst_v = 4'h0;     // Cold, warm, hot, core pulses
  logic [1:0]  dly = 2'h0;       // Scan answer delay
  logic        vld;              // Lock word valid
  logic [15:0] word;             // Lock word
  logic        rd, aprog, aerase, asel, mode_o, otpl_o, fbl_o, err_o;
  logic        done_o, busy_o;   // Status outputs
  logic [9:0]  ablk;             // Block of last op
  logic [5:0]  apage;            // Page of last op
  logic [15:0] buf_v = 16'hffff; // Buffer lock word
  int          err_count = 0;    // Mismatches
  int          n_checks = 0;     // Comparisons
  int          seed = 32'h7981;  // Random seed
  int          otp_lk, fb_lk, mode, blk; // Reference model state
  bit          pdone [64];       // OTP pages written since power-up
  logic [15:0] cell_m;           // Model of the lock word

  always #2 mclk_i = ~mclk_i;

  otpl_ctrl uut
  (
    .mclk_i(mclk_i), .arst_n_i(arst_n_i), .clk_en_i(1'b1),
    .fba_we_i(fba_we_i), .fba_i(fba_i), .prog_req_i(prog_req_i),
    .page_i(page_i), .erase_req_i(erase_req_i),
    .cold_rst_i(rst_v[0]), .warm_rst_i(rst_v[1]),
    .hot_rst_i(rst_v[2]), .core_rst_i(rst_v[3]),
    .lock_vld_i(vld), .lock_word_i(word), .lock_rd_o(rd),
    .arr_prog_o(aprog), .arr_erase_o(aerase), .arr_otp_sel_o(asel),
    .arr_blk_o(ablk), .arr_page_o(apage), .otp_mode_o(mode_o),
    .otp_locked_o(otpl_o), .first_block_locked_flag_o(fbl_o),
    .err_o(err_o), .done_o(done_o), .busy_o(busy_o)
  );

  otpl_lock_store store
  (
    .mclk_i(mclk_i), .arst_n_i(arst_n_i), .blank_i(blank), .rd_i(rd),
    .dly_i(dly), .prog_i(aprog), .sel_i(asel), .page_i(apage),
    .buf_i(buf_v), .vld_o(vld), .word_o(word)
  );

  // Report a mismatch at once and count every compare
  task automatic chk(input string nm, input logic [15:0] seen,
                     input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  // Wait out the lock scan, then compare flags with the model
  task automatic scan_done();
    begin
      for (int i = 0; i < 20 && busy_o !== 1'b0; i++)
      begin
        @(posedge mclk_i);
        #1;
      end
      chk("busy", busy_o, 0);
      chk("lock_rd", rd, 0);
      otp_lk = cell_m[7:0] inside {otpl_pkg::OTPL_CODE_OTP,
                                   otpl_pkg::OTPL_CODE_BOTH};
      fb_lk = cell_m[7:0] inside {otpl_pkg::OTPL_CODE_FBL,
                                  otpl_pkg::OTPL_CODE_BOTH};
      chk("otp_locked", otpl_o, otp_lk);
      chk("fb_locked", fbl_o, fb_lk);
    end
  endtask

  // Power up a fresh part: erased lock word, empty page map
  task automatic boot();
    begin
      @(posedge mclk_i);
      arst_n_i <= 1'b0;
      blank    <= 1'b1;
      dly      <= 2'($random(seed));
      repeat (3) @(posedge mclk_i);
      arst_n_i <= 1'b1;
      blank    <= 1'b0;
      cell_m = 16'hffff;
      mode = 0;
      blk = 0;
      pdone = '{default: 0};
      scan_done();
    end
  endtask

  // One reset command: 0 cold, 1 warm, 2 hot, 3 core
  task automatic rst(input int k);
    begin
      @(posedge mclk_i);
      rst_v <= 4'h1 << k;
      dly   <= 2'($random(seed));
      @(posedge mclk_i);
      rst_v <= 4'h0;
      #1;
      mode = 0;
      chk("mode_exit", mode_o, 0);
      chk("err_clr", err_o, 0);
      if (k == 0)
        scan_done();
      else
      begin
        chk("otp_keep", otpl_o, otp_lk);
        chk("fb_keep", fbl_o, fb_lk);
      end
    end
  endtask

  task automatic wr_fba(input logic [15:0] v);
    begin
      @(posedge mclk_i);
      fba_we_i <= 1'b1;
      fba_i    <= v;
      @(posedge mclk_i);
      fba_we_i <= 1'b0;
      #1;
      if (v == otpl_pkg::OTPL_ACCESS_CMD)
        mode = 1;
      else
        blk = v[9:0];
      chk("mode", mode_o, mode);
    end
  endtask

  // Program (er=0) or erase (er=1), judged one cycle after taking
  task automatic op(input int er, input int p);
    int e;
    begin
      if (er)
        e = mode || (blk == 0 && fb_lk);
      else if (mode)
        e = otp_lk || p >= 50 || (p != 0 && pdone[p]);
      else
        e = blk == 0 && fb_lk;
      @(posedge mclk_i);
      prog_req_i  <= !er;
      erase_req_i <= er;
      page_i      <= 6'(p);
      @(posedge mclk_i);
      prog_req_i  <= 1'b0;
      erase_req_i <= 1'b0;
      #1;
      chk("done", done_o, 1);
      chk("err", err_o, e);
      chk("issued", {aerase, aprog}, e ? 0 : (er ? 2 : 1));
      if (!e)
      begin
        chk("sel", asel, mode);
        chk("page", apage, er ? 0 : p);
        if (!mode)
          chk("blk", ablk, blk);
        if (mode && p != 0)
          pdone[p] = 1;
        if (mode && p == 0)
          cell_m = cell_m & buf_v;
      end
    end
  endtask

  // Lock sequence on the page 0 spare word, then a cold reset
  task automatic lock(input logic [7:0] code);
    begin
      wr_fba(otpl_pkg::OTPL_ACCESS_CMD);
      buf_v = {8'($random(seed)), code};
      wr_fba({6'h3f, 10'($random(seed))});
      op(0, 0);
      rst(0);
    end
  endtask

  task automatic close_out();
    if (err_count == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Watchdog: the whole sequence needs well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge mclk_i);
    err_count++;
    close_out();
  end

  // Scenario list, run once from power-up
  initial
  begin
    boot();
    // Plain block 0 before any lock behaves normally
    wr_fba(16'h0000);
    op(0, 5);
    op(1, 0);
    // OTP programs: once per page, user area only, no erase
    wr_fba(otpl_pkg::OTPL_ACCESS_CMD);
    op(0, 3);
    op(0, 3);
    op(0, 49);
    op(0, 50);
    op(0, 63);
    op(1, 0);
    // Warm, hot and core resets each leave OTP mode
    for (int k = 1; k < 4; k++)
    begin
      wr_fba(otpl_pkg::OTPL_ACCESS_CMD);
      rst(k);
    end
    lock(otpl_pkg::OTPL_CODE_FBL);
    wr_fba(16'h0000);
    op(0, 1);
    op(1, 0);
    // OTP lock after the first block lock
    lock(otpl_pkg::OTPL_CODE_OTP);
    wr_fba(otpl_pkg::OTPL_ACCESS_CMD);
    op(0, 7);
    op(0, 0);
    // Fresh part: an OTP lock shuts out the first block lock
    boot();
    lock(otpl_pkg::OTPL_CODE_OTP);
    lock(otpl_pkg::OTPL_CODE_FBL);
    // combined code on a fresh part
    boot();
    lock(otpl_pkg::OTPL_CODE_BOTH);
    wr_fba(16'h0000);
    op(0, 2);
    wr_fba(otpl_pkg::OTPL_ACCESS_CMD);
    op(0, 4);
    // Fresh part with a code that matches nothing
    boot();
    lock(8'h5a);
    close_out();
  end
endmodule // otpl_ctrl_tb

// file: bench/otpl_lock_store.sv
// Lock word cell of the OTP block, answering the boot-time scan
`timescale 1ns/1ps

module otpl_lock_store
(
  input  wire logic        mclk_i,    // Clock
  input  wire logic        arst_n_i,  // Power-up reset, low
  input  wire logic        blank_i,   // Fresh part: cell erased
  input  wire logic        rd_i,      // Scan request
  input  wire logic [1:0]  dly_i,     // Answer delay in cycles
  input  wire logic        prog_i,    // Accepted program pulse
  input  wire logic        sel_i,     // Program goes to OTP block
  input  wire logic [5:0]  page_i,    // Programmed page
  input  wire logic [15:0] buf_i,     // Buffer copy of the lock word
  output logic             vld_o,     // Lock word valid
  output logic [15:0]      word_o     // Lock word, scrambled when idle
);
  logic [15:0] cell_r;  // Stored word, survives every reset
  logic [1:0]  wait_r;  // Cycles left before answering

  // Programming only clears bits, as a real cell would
  always @(posedge mclk_i)
  begin
    if (blank_i)
      cell_r <= 16'hffff;
    else if (prog_i && sel_i && page_i == 6'h00)
      cell_r <= cell_r & buf_i;
  end

  // Inverted word off the valid cycle, so a stale sample cannot match
  always @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      vld_o  <= 1'b0;
      wait_r <= 2'h0;
      word_o <= 16'h0000;
    end
    else if (!vld_o && rd_i && wait_r == 2'h0)
    begin
      vld_o  <= 1'b1;
      word_o <= cell_r;
    end
    else
    begin
      vld_o  <= 1'b0;
      wait_r <= (rd_i && !vld_o) ? wait_r - 2'h1 : dly_i;
      word_o <= ~cell_r ^ {15'h0000, wait_r[0]};
    end
  end
endmodule // otpl_lock_store

// file: verilog/otpl_ctrl.sv
// OTP program and lock controller: access mode, lock flags, refusals
`timescale 1ns/1ps

// What this block does
// - OTP pages other than page 0 program once, never erased
// - Any of four resets leaves OTP mode
// - Boot lock code sets OTP locked flag
// - Program to locked OTP flags error
// - No OTP unlock; a page 0 reprogram can clear first-block lock at next boot; flags set only at boot
// - OTP locked blocks later first-block lock
// - Cold reset alone refreshes OTP lock flag
// - Boot first-block code sets bit five
// - Locked first block refuses erase, program
// - Program to locked first block flags error
// - OTP still lockable after first block
// - Combined code sets both flags
// - Access code as block address enters mode
// - Sixty-four pages; pages 50-63 are maker's
module otpl_ctrl
(
  input  wire logic        mclk_i,        // 250 MHz clock
  input  wire logic        arst_n_i,      // Power-up reset, async, low
  input  wire logic        clk_en_i,      // Low freezes all state
  input  wire logic        fba_we_i,      // Block address write strobe
  input  wire logic [15:0] fba_i,         // Block address or access code
  input  wire logic        prog_req_i,    // Program command pulse
  input  wire logic [5:0]  page_i,        // Target page of the program
  input  wire logic        erase_req_i,   // Block erase command pulse
  input  wire logic        cold_rst_i,    // Cold reset pulse
  input  wire logic        warm_rst_i,    // Warm reset pulse
  input  wire logic        hot_rst_i,     // Hot reset pulse
  input  wire logic        core_rst_i,    // Flash core reset pulse
  input  wire logic        lock_vld_i,    // Lock word read data valid
  input  wire logic [15:0] lock_word_i,   // Lock word from the OTP block
  output logic             lock_rd_o,     // Lock word read request
  output logic             arr_prog_o,    // Accepted program pulse
  output logic             arr_erase_o,   // Accepted erase pulse
  output logic             arr_otp_sel_o, // Operation goes to OTP block
  output logic [9:0]       arr_blk_o,     // Block of the operation
  output logic [5:0]       arr_page_o,    // Page of the operation
  output logic             otp_mode_o,    // OTP access mode active
  output logic             otp_locked_o,  // Status bit 6
  output logic             first_block_locked_flag_o, // Status bit 5
  output logic             err_o,         // Status error bit
  output logic             done_o,        // Command finished pulse
  output logic             busy_o         // Lock word scan running
);

  // State registers and their next values
  otpl_pkg::otpl_state_t   st_r,       st_nxt;       // Controller state
  logic                    otp_mode_r, otp_mode_nxt; // OTP access mode
  logic                    otp_lk_r,   otp_lk_nxt;   // OTP locked flag
  logic                    fbl_lk_r,   fbl_lk_nxt;   // First block locked
  logic                    err_r,      err_nxt;      // Error flag
  logic                    done_r,     done_nxt;     // Done pulse
  logic                    rd_r,       rd_nxt;       // Lock read request
  logic                    prog_r,     prog_nxt;     // Program pulse
  logic                    erase_r,    erase_nxt;    // Erase pulse
  logic                    sel_r,      sel_nxt;      // OTP select
  logic [9:0]              blk_r,      blk_nxt;      // Latched block
  logic [9:0]              oblk_r,     oblk_nxt;     // Issued block
  logic [5:0]              page_r,     page_nxt;     // Issued page
  logic [63:0]             used_r,     used_nxt;     // Programmed pages
  logic                    busy_r,     busy_nxt;     // Lock scan running

  // Decoder results and helper terms
  logic                    dec_otp;    // Lock word asks OTP lock
  logic                    dec_fbl;    // Lock word asks first block lock
  logic                    any_rst;    // Some reset command this cycle
  logic                    is_first;   // Latched block is the first one
  logic                    refuse;     // Current command is refused

  // Lock code decoder
  otpl_lock_dec u_dec
  (
    .word_i     (lock_word_i),
    .otp_lock_o (dec_otp),
    .fbl_lock_o (dec_fbl)
  );

  // Next-state logic for the whole controller
  always_comb
  begin
    st_nxt       = st_r;
    otp_mode_nxt = otp_mode_r;
    otp_lk_nxt   = otp_lk_r;
    fbl_lk_nxt   = fbl_lk_r;
    err_nxt      = err_r;
    blk_nxt      = blk_r;
    oblk_nxt     = oblk_r;
    page_nxt     = page_r;
    sel_nxt      = sel_r;
    used_nxt     = used_r;
    done_nxt     = 1'b0;
    prog_nxt     = 1'b0;
    erase_nxt    = 1'b0;
    rd_nxt       = 1'b0;
    refuse       = 1'b0;
    any_rst      = cold_rst_i | warm_rst_i | hot_rst_i | core_rst_i;
    is_first     = (blk_r == otpl_pkg::OTPL_FIRST_BLK);
    if (any_rst)
    begin
      // every reset kind exits OTP mode
      otp_mode_nxt = 1'b0;
      err_nxt      = 1'b0;
      // only cold reset rescans the word
      if (cold_rst_i)
      begin
        st_nxt = otpl_pkg::OTPL_ST_BOOT;
      end
    end
    else
    begin
      case (st_r)
        // Read the lock word, then settle the flags
        otpl_pkg::OTPL_ST_BOOT:
        begin
          rd_nxt = 1'b1;
          if (rd_r && lock_vld_i)
          begin
            otp_lk_nxt = dec_otp;
            fbl_lk_nxt = dec_fbl;
            rd_nxt     = 1'b0;
            st_nxt     = otpl_pkg::OTPL_ST_IDLE;
          end
        end
        // Accept host commands
        otpl_pkg::OTPL_ST_IDLE:
        begin
          if (fba_we_i)
          begin
            if (fba_i == otpl_pkg::OTPL_ACCESS_CMD)
            begin
              otp_mode_nxt = 1'b1;
            end
            else
            begin
              // any address taken in OTP mode
              blk_nxt = fba_i[9:0];
            end
          end
          else if (prog_req_i)
          begin
            if (otp_mode_r)
            begin
              // so the lock word is frozen too
              refuse = otp_lk_r
                     || (page_i >= otpl_pkg::OTPL_USER_PAGES)
                     || (used_r[page_i] &&
                         page_i != otpl_pkg::OTPL_LOCK_PAGE);
            end
            else
            begin
              refuse = is_first && fbl_lk_r;
            end
            done_nxt = 1'b1;
            err_nxt  = refuse;
            if (!refuse)
            begin
              // page 0 stays open for a later lock
              prog_nxt = 1'b1;
              sel_nxt  = otp_mode_r;
              oblk_nxt = blk_r;
              page_nxt = page_i;
              if (otp_mode_r)
              begin
                used_nxt[page_i] = 1'b1;
              end
            end
          end
          else if (erase_req_i)
          begin
            // no erase in the OTP block
            refuse   = otp_mode_r || (is_first && fbl_lk_r);
            done_nxt = 1'b1;
            err_nxt  = refuse;
            if (!refuse)
            begin
              erase_nxt = 1'b1;
              sel_nxt   = 1'b0;
              oblk_nxt  = blk_r;
              page_nxt  = 6'h00;
            end
          end
        end
        default:
        begin
          st_nxt = otpl_pkg::OTPL_ST_BOOT;
        end
      endcase
    end
    // Busy tracks the state being entered, so the pin comes from a flop
    busy_nxt     = (st_nxt == otpl_pkg::OTPL_ST_BOOT);
  end

  // Registers; the used-page map lives only until power is lost,
  // so the flash cells must also refuse a second program
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      st_r       <= otpl_pkg::OTPL_ST_BOOT;
      otp_mode_r <= 1'b0;
      otp_lk_r   <= otpl_pkg::OTPL_LOCK_RST;
      fbl_lk_r   <= otpl_pkg::OTPL_LOCK_RST;
      err_r      <= 1'b0;
      done_r     <= 1'b0;
      rd_r       <= 1'b0;
      prog_r     <= 1'b0;
      erase_r    <= 1'b0;
      sel_r      <= 1'b0;
      blk_r      <= otpl_pkg::OTPL_BLK_RST;
      oblk_r     <= otpl_pkg::OTPL_BLK_RST;
      page_r     <= 6'h00;
      used_r     <= 64'h0;
      busy_r     <= 1'b1;
    end
    else if (clk_en_i)
    begin
      st_r       <= st_nxt;
      otp_mode_r <= otp_mode_nxt;
      otp_lk_r   <= otp_lk_nxt;
      fbl_lk_r   <= fbl_lk_nxt;
      err_r      <= err_nxt;
      done_r     <= done_nxt;
      rd_r       <= rd_nxt;
      prog_r     <= prog_nxt;
      erase_r    <= erase_nxt;
      sel_r      <= sel_nxt;
      blk_r      <= blk_nxt;
      oblk_r     <= oblk_nxt;
      page_r     <= page_nxt;
      used_r     <= used_nxt;
      busy_r     <= busy_nxt;
    end
  end

  // Outputs straight from flops
  assign lock_rd_o                 = rd_r;
  assign arr_prog_o                = prog_r;
  assign arr_erase_o               = erase_r;
  assign arr_otp_sel_o             = sel_r;
  assign arr_blk_o                 = oblk_r;
  assign arr_page_o                = page_r;
  assign otp_mode_o                = otp_mode_r;
  assign otp_locked_o              = otp_lk_r;
  assign first_block_locked_flag_o = fbl_lk_r;
  assign err_o                     = err_r;
  assign done_o                    = done_r;
  assign busy_o                    = busy_r;

  // Checks on the controller behaviour
  a_boot_flag_load: assert property (
    @(posedge mclk_i) disable iff (!arst_n_i)
    (clk_en_i && st_r == otpl_pkg::OTPL_ST_BOOT && rd_r && lock_vld_i
     && !cold_rst_i && !warm_rst_i && !hot_rst_i && !core_rst_i)
    |=> (otp_lk_r == $past(dec_otp)) && (fbl_lk_r == $past(dec_fbl))
        && !busy_o)
    else $error("lock flags not loaded from lock word");

  a_otp_prog_err: assert property (
    @(posedge mclk_i) disable iff (!arst_n_i)
    (clk_en_i && st_r == otpl_pkg::OTPL_ST_IDLE && !any_rst && !fba_we_i
     && prog_req_i && otp_mode_r && otp_lk_r)
    |=> err_o && done_o && !arr_prog_o)
    else $error("program to locked OTP not flagged");

  a_fbl_prog_err: assert property (
    @(posedge mclk_i) disable iff (!arst_n_i)
    (clk_en_i && st_r == otpl_pkg::OTPL_ST_IDLE && !any_rst && !fba_we_i
     && prog_req_i && !otp_mode_r && is_first && fbl_lk_r)
    |=> err_o && !arr_prog_o)
    else $error("program to locked first block not flagged");

  a_no_otp_erase: assert property (
    @(posedge mclk_i) disable iff (!arst_n_i)
    arr_erase_o |-> !arr_otp_sel_o && !$past(otp_mode_r))
    else $error("erase issued in OTP mode");

  a_fbl_no_erase: assert property (
    @(posedge mclk_i) disable iff (!arst_n_i)
    (arr_erase_o || (arr_prog_o && !arr_otp_sel_o))
    |-> !(arr_blk_o == otpl_pkg::OTPL_FIRST_BLK && fbl_lk_r))
    else $error("locked first block was changed");

  a_flags_stable: assert property (
    @(posedge mclk_i) disable iff (!arst_n_i)
    (st_r == otpl_pkg::OTPL_ST_IDLE && $past(st_r) ==
     otpl_pkg::OTPL_ST_IDLE) |-> $stable(otp_lk_r) && $stable(fbl_lk_r))
    else $error("lock flag moved outside boot scan");

  a_mode_exit: assert property (
    @(posedge mclk_i) disable iff (!arst_n_i)
    (clk_en_i && any_rst) |=> !otp_mode_o ##1 (!otp_mode_o || $past(
     fba_we_i)))
    else $error("OTP mode survived a reset");

  a_mode_entry: assert property (
    @(posedge mclk_i) disable iff (!arst_n_i)
    (clk_en_i && st_r == otpl_pkg::OTPL_ST_IDLE && !any_rst && fba_we_i
     && fba_i == otpl_pkg::OTPL_ACCESS_CMD) |=> otp_mode_o
     && $stable(blk_r))
    else $error("access code did not enter OTP mode");

  a_maker_pages: assert property (
    @(posedge mclk_i) disable iff (!arst_n_i)
    (arr_prog_o && arr_otp_sel_o)
    |-> arr_page_o < otpl_pkg::OTPL_USER_PAGES)
    else $error("program reached a maker page");

  a_cold_rescan: assert property (
    @(posedge mclk_i) disable iff (!arst_n_i)
    (clk_en_i && cold_rst_i) |=> busy_o && !otp_mode_o)
    else $error("cold reset did not rescan lock word");

endmodule // otpl_ctrl

// file: verilog/otpl_lock_dec.sv
// Lock word decoder for the OTP program and lock controller
`timescale 1ns/1ps

module otpl_lock_dec
(
  input  wire logic [15:0] word_i,      // Lock word read from the OTP block
  output logic             otp_lock_o,  // Code asks for OTP block lock
  output logic             fbl_lock_o   // Code asks for first block lock
);

  logic [7:0] low_byte;  // Only the low byte carries the lock code

  // Decode the code; the high byte is free for the user
  always_comb
  begin
    low_byte   = word_i[7:0];
    otp_lock_o = 1'b0;
    fbl_lock_o = 1'b0;
    case (low_byte)
      otpl_pkg::OTPL_CODE_OTP:
      begin
        otp_lock_o = 1'b1;
      end
      otpl_pkg::OTPL_CODE_FBL:
      begin
        fbl_lock_o = 1'b1;
      end
      otpl_pkg::OTPL_CODE_BOTH:
      begin
        otp_lock_o = 1'b1;
        fbl_lock_o = 1'b1;
      end
      default:
      begin
        otp_lock_o = 1'b0;
        fbl_lock_o = 1'b0;
      end
    endcase
  end

endmodule // otpl_lock_dec

// file: verilog/otpl_pkg.sv
// Constants shared by the OTP program and lock controller
package otpl_pkg;

  // Block address written in place of a flash block to enter OTP access
  localparam logic [15:0] OTPL_ACCESS_CMD  = 16'h0065;

  // Lock codes, compared against the low byte of the lock word only
  localparam logic [7:0]  OTPL_CODE_OTP    = 8'hfc;
  localparam logic [7:0]  OTPL_CODE_FBL    = 8'hf3;
  localparam logic [7:0]  OTPL_CODE_BOTH   = 8'hf0;

  // Lock word location: page 0, sector 0 spare area, eighth word
  localparam logic [5:0]  OTPL_LOCK_PAGE   = 6'h00;
  localparam logic [1:0]  OTPL_LOCK_SECTOR = 2'h0;
  localparam logic [3:0]  OTPL_LOCK_WORD   = 4'h7;

  // Field widths
  localparam int          OTPL_BLK_W       = 10;
  localparam int          OTPL_PAGE_W      = 6;

  // OTP block geometry: 64 pages, user pages 0 to 49, 14 maker pages
  localparam int          OTPL_PAGES       = 64;
  localparam logic [5:0]  OTPL_USER_PAGES  = 6'h32;

  // First array block, the one that can be locked as OTP
  localparam logic [9:0]  OTPL_FIRST_BLK   = 10'h000;

  // Controller status bit positions of the two lock flags
  localparam int          OTPL_STAT_FBL    = 5;
  localparam int          OTPL_STAT_OTP    = 6;

  // Reset values of the lock flags and of the block address
  localparam logic        OTPL_LOCK_RST    = 1'b0;
  localparam logic [9:0]  OTPL_BLK_RST     = 10'h000;

  // Controller states
  typedef enum logic [0:0]
  {
    OTPL_ST_BOOT = 1'b0,
    OTPL_ST_IDLE = 1'b1
  } otpl_state_t;

endpackage
